// *** core/gpio_bank.sv ***
// Four general purpose ports, A to D with 8, 7, 7 and 4 pins, reached as data-memory registers.
// Assumes the core presents one read or write per enabled cycle; pin levels
// are synchronous to clk_sys and pin function comes from the function selects.
`timescale 1ns/100ps
`include "gpio_defines.svh"

module gpio_bank
    import gpio_pkg::*;
#(
    parameter int NPORT = `GP_NPORT
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clk_en,
    // Data-memory register access
    input wire gp_req_s req,
    output logic [7:0] rdata,
    // Processor power state
    input wire logic low_power,
    // Pin function per port, two bits per pin
    input wire logic [NPORT-1:0][15:0] pin_function,
    // Pins
    input wire logic [NPORT-1:0][7:0] pin_in,
    output gp_port_pins_s [NPORT-1:0] pins,
    // Power management
    output logic wake_req
);

    // Register map and masks are fixed for four ports
    if (NPORT != `GP_NPORT) begin : g_bad_nport
        $error("gpio_bank supports exactly four ports");
    end

    gp_state_s s_q;
    gp_state_s s_d;

    // Implemented bits of each port
    function automatic logic [7:0] port_mask(input int p);
        case (p)
            0: port_mask = `GP_MASK_A;
            1: port_mask = `GP_MASK_B;
            2: port_mask = `GP_MASK_C;
            default: port_mask = `GP_MASK_D;
        endcase
    endfunction

    // Two-bit function field of one pin
    function automatic gp_fn_e pin_fn(input logic [15:0] f, input int b);
        logic [1:0] code;
        code = f[2*b +: 2];
        case (code)
            `GP_FN_GPIO: pin_fn = GP_FN_GPIO_E;
            `GP_FN_OPEN_DRAIN: pin_fn = GP_FN_OD_E;
            default: pin_fn = GP_FN_OTHER_E;
        endcase
    endfunction

    // Port index of a data/dir/pullup register, or NPORT if none
    function automatic logic [2:0] reg_port(input logic [`GP_ADDR_W-1:0] a);
        case (a)
            `GP_IDX_A_DATA, `GP_IDX_A_DIR, `GP_IDX_A_PU: reg_port = 3'h0;
            `GP_IDX_B_DATA, `GP_IDX_B_DIR, `GP_IDX_B_PU: reg_port = 3'h1;
            `GP_IDX_C_DATA, `GP_IDX_C_DIR, `GP_IDX_C_PU: reg_port = 3'h2;
            `GP_IDX_D_DATA, `GP_IDX_D_DIR, `GP_IDX_D_PU: reg_port = 3'h3;
            default: reg_port = 3'h4;
        endcase
    endfunction

    logic [NPORT-1:0][7:0] read_view;
    logic [7:0] pa_fall;
    logic [7:0] pa_gp_in;

    // Input pins read live, output pins read the latch
    for (genvar p = 0; p < NPORT; p++) begin : g_view
        for (genvar b = 0; b < 8; b++) begin : g_bit
            assign read_view[p][b] = s_q.dir[p][b] ? pin_in[p][b]
                                                   : s_q.data[p][b];
        end
    end

    for (genvar b = 0; b < 8; b++) begin : g_wake
        assign pa_gp_in[b] = s_q.dir[0][b] && (pin_fn(pin_function[0], b) == GP_FN_GPIO_E);
    end
    // Edge compares against the level held at the previous enabled cycle
    assign pa_fall = s_q.pa_prev & ~pin_in[0] & s_q.wake_en & pa_gp_in;

    always_comb begin
        logic [2:0] rp;
        logic [7:0] m;
        s_d = s_q;
        rp = reg_port(req.addr);
        m = (rp < 3'h4) ? port_mask(int'(rp)) : 8'h00;
        s_d.pa_prev = pin_in[0];
        s_d.wake_req = low_power && (|pa_fall);
        if (req.wr) begin
            unique case (req.addr)
                `GP_IDX_A_DATA, `GP_IDX_B_DATA, `GP_IDX_C_DATA, `GP_IDX_D_DATA: begin
                    s_d.data[rp[1:0]] = req.wdata & m;
                end
                `GP_IDX_A_DIR, `GP_IDX_B_DIR, `GP_IDX_C_DIR, `GP_IDX_D_DIR: begin
                    s_d.dir[rp[1:0]] = (req.wdata & m) | ~m;
                end
                `GP_IDX_A_PU, `GP_IDX_B_PU, `GP_IDX_C_PU, `GP_IDX_D_PU: begin
                    s_d.pu[rp[1:0]] = req.wdata & m;
                end
                `GP_IDX_A_WAKE: s_d.wake_en = req.wdata;
                `GP_IDX_LOW_VOLTAGE_PULLUP_SELECT: s_d.low_voltage_pullup_select = req.wdata & `GP_MASK_LOW_VOLTAGE_PULLUP_SELECT;
                `GP_IDX_DRV0: s_d.drv0 = req.wdata & `GP_MASK_DRV0;
                `GP_IDX_DRV1: s_d.drv1 = req.wdata & `GP_MASK_DRV1;
                default: ;
            endcase
        end
        if (req.rd) begin
            unique case (req.addr)
                `GP_IDX_A_DATA, `GP_IDX_B_DATA, `GP_IDX_C_DATA, `GP_IDX_D_DATA: begin
                    s_d.rdata = read_view[rp[1:0]] & m;
                end
                `GP_IDX_A_DIR, `GP_IDX_B_DIR, `GP_IDX_C_DIR, `GP_IDX_D_DIR: begin
                    s_d.rdata = s_q.dir[rp[1:0]] & m;
                end
                `GP_IDX_A_PU, `GP_IDX_B_PU, `GP_IDX_C_PU, `GP_IDX_D_PU: begin
                    s_d.rdata = s_q.pu[rp[1:0]] & m;
                end
                `GP_IDX_A_WAKE: s_d.rdata = s_q.wake_en;
                `GP_IDX_LOW_VOLTAGE_PULLUP_SELECT: s_d.rdata = s_q.low_voltage_pullup_select;
                `GP_IDX_DRV0: s_d.rdata = s_q.drv0;
                `GP_IDX_DRV1: s_d.rdata = s_q.drv1;
                default: s_d.rdata = `GP_RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_q.data <= '0;
            for (int p = 0; p < NPORT; p++) begin
                s_q.dir[p] <= `GP_RST_DIR;
            end
            s_q.pu <= '0;
            s_q.wake_en <= `GP_RST_ZERO;
            s_q.low_voltage_pullup_select <= `GP_RST_ZERO;
            s_q.drv0 <= `GP_RST_ZERO;
            s_q.drv1 <= `GP_RST_ZERO;
            s_q.rdata <= `GP_RST_ZERO;
            s_q.pa_prev <= `GP_RST_ZERO;
            s_q.wake_req <= 1'b0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign wake_req = s_q.wake_req;

    // Drive field per pin; groups A3-0, A7-4, B3, B6-5, C2-0
    function automatic logic [1:0] drv_of(input logic [7:0] d0, input logic [7:0] d1,
                                          input int p, input int b);
        drv_of = `GP_DRV_MIN;
        if (p == 0) begin
            drv_of = (b < 4) ? d0[1:0] : d0[3:2];
        end else if (p == 1 && b == 3) begin
            drv_of = d0[5:4];
        end else if (p == 1 && (b == 5 || b == 6)) begin
            drv_of = d0[7:6];
        end else if (p == 2 && b < 3) begin
            drv_of = d1[1:0];
        end
    endfunction

    for (genvar p = 0; p < NPORT; p++) begin : g_pin
        localparam logic [7:0] PMASK = port_mask(p);
        for (genvar b = 0; b < 8; b++) begin : g_bit
            logic out_mode;
            logic pu_ok;
            assign out_mode = !s_q.dir[p][b] && PMASK[b];
            assign pu_ok = s_q.pu[p][b] && ((s_q.dir[p][b] &&
                           pin_fn(pin_function[p], b) == GP_FN_GPIO_E) ||
                           pin_fn(pin_function[p], b) == GP_FN_OD_E);
            assign pins[p].pin_out[b] = s_q.data[p][b];
            assign pins[p].pin_oe[b] = out_mode;
            assign pins[p].pullup_on[b] = pu_ok;
            assign pins[p].pullup_strong[b] = pu_ok && s_q.low_voltage_pullup_select[`GP_LOW_VOLTAGE_PULLUP_SELECT_BIT];
            assign pins[p].drive_level[2*b +: 2] = out_mode ?
                drv_of(s_q.drv0, s_q.drv1, p, b) : `GP_DRV_MIN;
        end
    end

endmodule

// *** core/gpio_defines.svh ***
// Constants for the four-port pin bank: register indices, masks, reset values.
// Assumes inclusion by the package, the pin bank module and its checker only.
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

`define GP_IDX_A_DATA 5'h00
`define GP_IDX_A_DIR 5'h01
`define GP_IDX_A_PU 5'h02
`define GP_IDX_A_WAKE 5'h03
`define GP_IDX_B_DATA 5'h04
`define GP_IDX_B_DIR 5'h05
`define GP_IDX_B_PU 5'h06
`define GP_IDX_C_DATA 5'h07
`define GP_IDX_C_DIR 5'h08
`define GP_IDX_C_PU 5'h09
`define GP_IDX_D_DATA 5'h0a
`define GP_IDX_D_DIR 5'h0b
`define GP_IDX_D_PU 5'h0c
`define GP_IDX_LOW_VOLTAGE_PULLUP_SELECT 5'h0d
`define GP_IDX_DRV0 5'h0e
`define GP_IDX_DRV1 5'h0f

`define GP_MASK_A 8'hff
`define GP_MASK_B 8'h7f
`define GP_MASK_C 8'h7f
`define GP_MASK_D 8'h0f
`define GP_MASK_LOW_VOLTAGE_PULLUP_SELECT 8'h01
`define GP_MASK_DRV0 8'hff
`define GP_MASK_DRV1 8'h3f

`define GP_RST_DIR 8'hff
`define GP_RST_ZERO 8'h00

`define GP_FN_GPIO 2'h0
`define GP_FN_OPEN_DRAIN 2'h1
`define GP_FN_OTHER 2'h2
`define GP_DRV_MIN 2'h0
`define GP_DRV_LOW_MID 2'h1
`define GP_DRV_HIGH_MID 2'h2
`define GP_DRV_MAX 2'h3

`define GP_LOW_VOLTAGE_PULLUP_SELECT_BIT 0
`define GP_NPORT 4
`define GP_ADDR_W 5

`endif

// *** core/gpio_pkg.sv ***
// Types shared by the pin bank: register bus request, pin bundle, state.
// Assumes gpio_defines.svh is on the include path.
`include "gpio_defines.svh"

package gpio_pkg;

    // Pin function as seen by the pull-up and wake logic
    typedef enum logic [1:0] {
        GP_FN_GPIO_E = `GP_FN_GPIO,
        GP_FN_OD_E = `GP_FN_OPEN_DRAIN,
        GP_FN_OTHER_E = `GP_FN_OTHER
    } gp_fn_e;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [`GP_ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } gp_req_s;

    typedef struct packed {
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
        logic [7:0] pullup_on;
        logic [7:0] pullup_strong;
        logic [15:0] drive_level;
    } gp_port_pins_s;

    typedef struct packed {
        logic [`GP_NPORT-1:0][7:0] data;
        logic [`GP_NPORT-1:0][7:0] dir;
        logic [`GP_NPORT-1:0][7:0] pu;
        logic [7:0] wake_en;
        logic [7:0] low_voltage_pullup_select;
        logic [7:0] drv0;
        logic [7:0] drv1;
        logic [7:0] rdata;
        logic [7:0] pa_prev;
        logic wake_req;
    } gp_state_s;

endpackage

// *** tb/gp_bank_checker.sv ***
// Port assertions for the pin bank.
// Assumes a bind onto gpio_bank; sees its ports only.
`timescale 1ns/100ps
`include "gpio_defines.svh"
module gp_bank_checker
    import gpio_pkg::*;
#(parameter int NPORT = 4) (
    // Inputs of the bank
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clk_en,
    input wire gp_req_s req,
    input wire logic low_power,
    input wire logic [NPORT-1:0][15:0] pin_function,
    input wire logic [NPORT-1:0][7:0] pin_in,
    // Outputs of the bank
    input wire logic [7:0] rdata,
    input wire gp_port_pins_s [NPORT-1:0] pins,
    input wire logic wake_req
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic [NPORT-1:0][7:0] pu_bad, st_bad, dr_bad;
    logic [NPORT-1:0][15:0] latch_v;
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            st_bad[p] = pins[p].pullup_strong & ~pins[p].pullup_on;
            latch_v[p] = {pins[p].pin_out, pins[p].pin_oe};
            for (int b = 0; b < 8; b++) begin
                pu_bad[p][b] = pins[p].pullup_on[b] && (pin_function[p][2*b+1]
                    || (pin_function[p][2*b+:2] == `GP_FN_GPIO && pins[p].pin_oe[b]));
                dr_bad[p][b] = !pins[p].pin_oe[b] && pins[p].drive_level[2*b+:2] != 2'h0;
            end
        end
    end
    sequence rd_a;
        clk_en && req.rd && req.addr == `GP_IDX_A_DATA;
    endsequence
    pullup_func_a: assert property (pu_bad == '0)
        else $error("pull-up on in wrong mode");
    strong_gate_a: assert property (st_bad == '0)
        else $error("strong pull-up without pull-up");
    drive_gate_a: assert property (dr_bad == '0)
        else $error("drive level on non-output");
    read_input_a: assert property (rd_a |=>
        ((rdata ^ $past(pin_in[0])) & ~$past(pins[0].pin_oe)) == 8'h00)
        else $error("input read not live level");
    read_latch_a: assert property (rd_a |=>
        ((rdata ^ $past(pins[0].pin_out)) & $past(pins[0].pin_oe)) == 8'h00)
        else $error("output read not latch");
    latch_hold_a: assert property (!(clk_en && req.wr) |=> $stable(latch_v))
        else $error("latch moved without write");
    rdata_hold_a: assert property (!(clk_en && req.rd) |=> $stable(rdata))
        else $error("read data moved without read");
    unmapped_zero_a: assert property (clk_en && req.rd && req.addr[4] |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    low_voltage_pullup_select_zero_a: assert property (clk_en && req.rd && req.addr == `GP_IDX_LOW_VOLTAGE_PULLUP_SELECT
        |=> rdata[7:1] == 7'h00)
        else $error("strength upper bits not zero");
    wake_cause_a: assert property (wake_req |-> $past(low_power) &&
        |($past(pin_in[0], 2) & ~$past(pin_in[0]) & ~$past(pins[0].pin_oe)))
        else $error("wake without falling input");
    wake_pulse_a: assert property (wake_req |=> !wake_req)
        else $error("wake longer than one cycle");
endmodule

// *** tb/gp_pin_model.sv ***
// Switches and floating lines in front of the pins.
// Assumes one bank on the same clock.
`timescale 1ns/100ps
module gp_pin_model
    import gpio_pkg::*;
#(parameter int NPORT = 4) (
    // Clock
    input wire logic clk_sys,
    // Bank drivers and switches
    input wire gp_port_pins_s [NPORT-1:0] pins,
    input wire logic [NPORT-1:0][7:0] sw_en,
    input wire logic [NPORT-1:0][7:0] sw_val,
    // Levels seen by the bank
    output logic [NPORT-1:0][7:0] pin_in
);
    // Floating lines wander so a missing pull-up shows
    logic [NPORT-1:0][7:0] float_q = '0;
    always @(posedge clk_sys) float_q <= ~float_q;
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (pins[p].pin_oe[b]) begin
                    pin_in[p][b] = pins[p].pin_out[b];
                end else if (sw_en[p][b]) begin
                    pin_in[p][b] = sw_val[p][b];
                end else begin
                    pin_in[p][b] = pins[p].pullup_on[b] | float_q[p][b];
                end
            end
        end
    end
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the pin bank.
// Assumes the package and defines are compiled first.
`timescale 1ns/100ps
module tb;
    import gpio_pkg::*;
    logic clk_sys = 0, rstn = 0, clk_en = 1, low_power = 0, wake_req;
    gp_req_s req = '0;
    logic [7:0] rdata;
    logic [3:0][15:0] fn = '0;
    logic [3:0][7:0] pin_in, sw_en = '1, sw_val = '0;
    gp_port_pins_s [3:0] pins;
    int error_cnt = 0, checks = 0;
    localparam logic [4:0] IDX [12] = '{1, 2, 3, 5, 6, 8, 9, 11, 12, 13, 14, 15};
    localparam logic [7:0] RST [12] = '{255, 0, 0, 127, 0, 127, 0, 15, 0, 0, 0, 0};
    localparam logic [7:0] MSK [12] = '{255, 255, 255, 127, 127, 127, 127, 15, 15, 1, 255, 63};
    always #2 clk_sys = ~clk_sys;
    gpio_bank u_gpio_bank (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .req(req),
        .rdata(rdata), .low_power(low_power), .pin_function(fn), .pin_in(pin_in),
        .pins(pins), .wake_req(wake_req));
    gp_pin_model u_gp_pin_model (.clk_sys(clk_sys), .pins(pins), .sw_en(sw_en),
        .sw_val(sw_val), .pin_in(pin_in));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task test_done;
        $display("errors=%0d checks=%0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task wr(input logic [4:0] a, input logic [7:0] v);
        @(posedge clk_sys) #1 req = '{rd: 0, wr: 1, addr: a, wdata: v};
        @(posedge clk_sys) #1 req.wr = 0;
    endtask
    task rd(input logic [4:0] a, input logic [7:0] exp);
        @(posedge clk_sys) #1 req = '{rd: 1, wr: 0, addr: a, wdata: 0};
        @(posedge clk_sys) #1 req.rd = 0;
        chk(16'(rdata), 16'(exp));
    endtask
    task t_regs;
        for (int i = 0; i < 12; i++) rd(IDX[i], RST[i]);
        for (int i = 0; i < 12; i++) begin
            wr(IDX[i], 8'hff);
            rd(IDX[i], MSK[i]);
        end
        wr(5'h10, 8'hff);
        rd(5'h10, 8'h00);
    endtask
    task t_latch;
        wr(5'h01, 8'h00);
        wr(5'h00, 8'ha5);
        sw_val[0] = 8'h5a;
        rd(5'h00, 8'ha5);
        wr(5'h01, 8'hff);
        rd(5'h00, 8'h5a);
        sw_val[0] = 8'h3c;
        rd(5'h00, 8'h3c);
        chk(16'(pins[0].pin_out), 16'ha5);
    endtask
    task t_pull;
        sw_en[0] = 8'h00;
        wr(5'h0d, 8'h00);
        rd(5'h00, 8'hff);
        chk(16'(pins[0].pullup_strong), 16'h00);
        wr(5'h0d, 8'h01);
        chk(16'(pins[0].pullup_strong), 16'hff);
        fn[0] = 16'haaaa;
        #1 chk(16'(pins[0].pullup_on), 16'h00);
        fn[0] = 16'h5555;
        wr(5'h01, 8'h00);
        chk(16'(pins[0].pullup_on), 16'hff);
        fn[0] = '0;
        wr(5'h01, 8'hff);
        wr(5'h02, 8'h00);
        chk(16'(pins[0].pullup_strong), 16'h00);
        sw_en[0] = 8'hff;
    endtask
    task t_drive;
        wr(5'h0e, 8'he4);
        wr(5'h0f, 8'h03);
        wr(5'h01, 8'h00);
        wr(5'h05, 8'h00);
        wr(5'h08, 8'h00);
        chk(pins[0].drive_level, 16'h5500);
        chk(pins[1].drive_level, 16'h3c80);
        chk(pins[2].drive_level, 16'h003f);
        wr(5'h01, 8'hff);
        chk(pins[0].drive_level, 16'h0000);
    endtask
    task t_hold;
        clk_en = 0;
        wr(5'h01, 8'h00);
        clk_en = 1;
        chk(16'(pins[0].pin_oe), 16'h00);
        rd(5'h01, 8'hff);
        wr(5'h03, 8'hff);
        @(posedge clk_sys) #1 rstn = 0;
        #4 rstn = 1;
        rd(5'h03, 8'h00);
        rd(5'h0e, 8'h00);
        rd(5'h05, 8'h7f);
        chk(16'(pins[1].pin_oe), 16'h00);
    endtask
    task wake_try(input logic lp, input int b, input logic exp);
        logic hit;
        hit = 0;
        low_power = lp;
        sw_val[0][b] = 1;
        repeat (2) @(posedge clk_sys);
        #1 sw_val[0][b] = 0;
        repeat (4) @(posedge clk_sys) #1 hit |= wake_req;
        chk(16'(hit), 16'(exp));
        if (exp && !hit) test_done;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        #1 rstn = 1;
        t_regs;
        t_latch;
        t_pull;
        t_drive;
        t_hold;
        wr(5'h03, 8'h01);
        wake_try(1, 0, 1);
        wake_try(1, 1, 0);
        wake_try(0, 0, 0);
        test_done;
    end
endmodule
bind gpio_bank gp_bank_checker #(.NPORT(NPORT)) u_gp_bank_checker (.clk_sys(clk_sys),
    .rstn(rstn), .clk_en(clk_en), .req(req), .low_power(low_power),
    .pin_function(pin_function), .pin_in(pin_in), .rdata(rdata), .pins(pins),
    .wake_req(wake_req));
